// >>> bridge_asserts.sv
// Port checker for the bridge top level, bound to every instance.
// Assumes one clock mclk and a synchronous active-low reset rst_b.
`default_nettype none

module bridge_asserts (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic hostTxValid,
    input wire logic hostTxReady,
    input wire logic [7:0] hostRxData,
    input wire logic hostRxValid,
    input wire logic hostRxReady,
    input wire logic usbEnumerate,
    input wire logic cfgVcpOption,
    input wire logic virtualSerialPortLayer,
    input wire logic sclIn,
    input wire logic sdaOut,
    input wire logic sdaOeN,
    input wire logic txDataPendingN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence rxStall;
        hostRxValid && !hostRxReady;
    endsequence

    sequence enumPulse;
        usbEnumerate && clkEn;
    endsequence

    sequence txPush;
        hostTxValid && hostTxReady && clkEn;
    endsequence

    property optLoad;
        enumPulse |=> virtualSerialPortLayer == $past(cfgVcpOption);
    endproperty

    rx_hold_a: assert property (rxStall |=> hostRxValid && $stable(hostRxData))
        else $error("host rx byte changed before accept");
    tx_full_a: assert property ($fell(hostTxReady) |-> $past(hostTxValid))
        else $error("tx ready fell without a push");
    pend_set_a: assert property (txPush |-> ##[1:2] !txDataPendingN)
        else $error("pending pin not set after push");
    pend_room_a: assert property (txDataPendingN |-> hostTxReady)
        else $error("empty tx buffer without room");
    enum_load_a: assert property (optLoad)
        else $error("option bit not reported on enumeration");
    opt_hold_a: assert property (!usbEnumerate |=> $stable(virtualSerialPortLayer))
        else $error("option bit changed without enumeration");
    sda_low_a: assert property (sdaOut == 1'b0)
        else $error("data pin value not low");
    sda_edge_a: assert property ($changed(sdaOeN) |-> !sclIn)
        else $error("data pin changed while clock high");
endmodule

bind usb_to_i2c_slave_data_bridge bridge_asserts chk_u (
    .mclk(mclk), .rst_b(rst_b), .clkEn(clkEn), .hostTxValid(hostTxValid),
    .hostTxReady(hostTxReady), .hostRxData(hostRxData), .hostRxValid(hostRxValid),
    .hostRxReady(hostRxReady), .usbEnumerate(usbEnumerate), .cfgVcpOption(cfgVcpOption),
    .virtualSerialPortLayer(virtualSerialPortLayer), .sclIn(sclIn), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .txDataPendingN(txDataPendingN)
);

`default_nettype wire

// >>> bridge_defs.svh
// Constants for the USB to two-wire slave data bridge.
// Assumes inclusion by its bare name from every file that needs a figure.
`ifndef BRIDGE_DEFS_SVH
`define BRIDGE_DEFS_SVH

`define MCLK_MHZ 20
`define LATENCY_TIME_US 16000
`define FIFO_DEPTH 8
`define BYTE_WIDTH 8
`define BYTE_BITS 4'd8
`define GC_ADDRESS 8'h00
`define GC_CMD_COUNT 8'h0c
`define GC_CMD_RESET 8'h06
`define GC_CMD_FLUSH 8'h0e
`define COUNT_SATURATE 16'h00ff
`define EMPTY_READ_BYTE 8'hff
`define SLAVE_ADDR_DEFAULT 7'h22

`endif

// >>> bridge_pkg.sv
// Types shared by the bridge modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package bridge_pkg;

    typedef enum logic [2:0] {
        LINE_IDLE,
        LINE_ADDR,
        LINE_ADDR_ACK,
        LINE_WR_DATA,
        LINE_WR_ACK,
        LINE_RD_DATA,
        LINE_RD_ACK
    } line_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } line_s;

endpackage

`default_nettype wire

// >>> i2c_master_model.sv
// Behavioural two-wire bus master that drives the serial clock and data.
// Assumes a pulled-up data wire computed by the bench from all drivers.
`default_nettype none

module i2c_master_model (
    input wire logic mclk,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaM
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int Q = 10;

    initial begin
        scl = 1'b1;
        sdaM = 1'b1;
    end

    task automatic tick();
        repeat (Q) @(posedge mclk);
        #5;
    endtask

    task automatic start();
        sdaM = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sdaM = 1'b0;
        tick();
        scl = 0;
        tick();
    endtask

    task automatic stop();
        sdaM = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sdaM = 1'b1;
        tick();
    endtask

    // Data moves only while the clock is low; a read releases every bit.
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sdaM = d[i];
            tick();
            scl = 1'b1;
            tick();
            r[i] = sdaLine;
            scl = 1'b0;
        end
        sdaM = mack;
        tick();
        scl = 1'b1;
        tick();
        ack = sdaLine;
        scl = 1'b0;
        tick();
        sdaM = 1'b1;
    endtask
endmodule

`default_nettype wire

// >>> tb_usb_to_i2c_slave_data_bridge.sv
// Self-checking bench for the bridge with a serial master model and host queues.
// Assumes bridge_defs.svh and the design files are compiled first.
`default_nettype none
`include "bridge_defs.svh"

module tb_usb_to_i2c_slave_data_bridge;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT = 2000;
    localparam logic [6:0] ADDR = `SLAVE_ADDR_DEFAULT;
    logic mclk, rst_b, clkEn, hostTxValid, hostTxReady, hostRxValid, hostRxReady;
    logic usbEnumerate, cfgVcpOption, virtualSerialPortLayer, scl, sdaM, sdaLine;
    logic sdaOut, sdaOeN, txDataPendingN, rxSpaceFreeN, ack;
    logic [7:0] hostTxData, hostRxData, r;
    logic [4:0] rstSeen;
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    logic [31:0] seed = 32'h40;
    int nMismatch = 0;
    int checks = 0;
    int cyc = 0;

    assign sdaLine = sdaM & (sdaOeN | sdaOut);

    usb_to_i2c_slave_data_bridge #(.LATENCY_CYCLES(LAT)) dut_u (
        .mclk(mclk), .rst_b(rst_b), .clkEn(clkEn), .hostTxData(hostTxData),
        .hostTxValid(hostTxValid), .hostTxReady(hostTxReady), .hostRxData(hostRxData),
        .hostRxValid(hostRxValid), .hostRxReady(hostRxReady), .usbEnumerate(usbEnumerate),
        .cfgVcpOption(cfgVcpOption), .virtualSerialPortLayer(virtualSerialPortLayer),
        .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
        .txDataPendingN(txDataPendingN), .rxSpaceFreeN(rxSpaceFreeN)
    );
    i2c_master_model mst (.mclk(mclk), .sdaLine(sdaLine), .scl(scl), .sdaM(sdaM));

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            nMismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        if (nMismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask

    // Burst read of n bytes; the first is the available count when cnt is set.
    task automatic sRead(input int n, input bit cnt, input bit nak);
        logic [7:0] e;
        mst.start();
        mst.xfer({ADDR, 1'b1}, 1'b1, r, ack);
        chk("rdAddrAck", nak, ack);
        for (int k = 0; k < n; k++) begin
            mst.xfer(8'hff, k == n - 1, r, ack);
            if (cnt && k == 0) begin
                e = (txq.size() > 255) ? 8'hff : 8'(txq.size());
            end else begin
                e = txq.pop_front();
            end
            chk("rdByte", e, r);
        end
        mst.stop();
    endtask

    task automatic sWrite(input logic [6:0] a, input int n, input int nakAt);
        logic [7:0] d;
        mst.start();
        mst.xfer({a, 1'b0}, 1'b1, r, ack);
        chk("wrAddrAck", 0, ack);
        for (int k = 0; k < n; k++) begin
            d = (a == 7'h00) ? `GC_CMD_COUNT : rnd();
            mst.xfer(d, 1'b1, r, ack);
            chk("wrAck", k >= nakAt, ack);
            if (a != 7'h00 && ack === 1'b0) rxq.push_back(d);
            if (a != 7'h00 && k == `FIFO_DEPTH - 1) begin
                cycles(5);
                chk("fullFwd", 1, hostRxValid);
            end
        end
        mst.stop();
    endtask

    task automatic drain(input int lim);
        for (int w = 0; w < lim && rxq.size() > 0; w++) cycles(1);
        chk("drained", 0, rxq.size());
    endtask

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            nMismatch++;
            print_verdict();
        end
        if (rst_b && hostRxValid === 1'b1 && hostRxReady === 1'b1)
            chk("hostRxData", rxq.size() ? rxq.pop_front() : 16'h1ff, hostRxData);
    end

    initial begin
        {rst_b, clkEn, hostTxValid, hostRxReady, usbEnumerate, cfgVcpOption} = 6'b010000;
        hostTxData = 8'h00;
        cycles(6);
        rstSeen = {hostTxReady, hostRxValid, sdaOeN, txDataPendingN, virtualSerialPortLayer};
        chk("rstOut", 5'b10110, rstSeen);
        rst_b = 1'b1;
        cycles(3);
        chk("rxFree", 0, rxSpaceFreeN);
        for (int v = 1; v >= 0; v--) begin
            cfgVcpOption = v[0];
            usbEnumerate = 1'b1;
            cycles(1);
            usbEnumerate = 1'b0;
            cycles(1);
            chk("vcpOpt", v, virtualSerialPortLayer);
        end
        // An enumeration pulse while the clock enable is low must be ignored.
        cfgVcpOption = 1'b1;
        usbEnumerate = 1'b1;
        clkEn = 1'b0;
        cycles(1);
        usbEnumerate = 1'b0;
        clkEn = 1'b1;
        cycles(1);
        chk("frozenOpt", 0, virtualSerialPortLayer);
        sRead(0, 0, 1);
        hostTxValid = 1'b1;
        for (int i = 0; i <= `FIFO_DEPTH; i++) begin
            hostTxData = rnd();
            chk("txReady", txq.size() < `FIFO_DEPTH, hostTxReady);
            if (hostTxReady === 1'b1) txq.push_back(hostTxData);
            cycles(1);
        end
        hostTxValid = 1'b0;
        cycles(2);
        chk("txPend", 0, txDataPendingN);
        sWrite(7'h00, 1, 9);
        sRead(`FIFO_DEPTH + 1, 1, 0);
        cycles(2);
        chk("txEmpty", 1, txDataPendingN);
        sWrite(ADDR, `FIFO_DEPTH + 2, `FIFO_DEPTH + 1);
        hostRxReady = 1'b1;
        drain(100);
        for (int n = 1; n <= 2; n++) begin
            sWrite(ADDR, n, 9);
            chk("noEarly", 0, hostRxValid);
            drain(LAT);
        end
        print_verdict();
    end
endmodule

`default_nettype wire

// >>> usb_to_i2c_slave_data_bridge.sv
// Data path of a USB to two-wire slave bridge: FIFO and top level.
// Assumes a byte stream from and to the USB function on mclk and a two-wire
// master that alone drives the serial clock.
//
// Contract
// - Bytes from the USB host go into the transmit buffer and leave through slave reads.
// - Bytes written by the master are stored in the receive buffer and forwarded upstream.
// - Receive data goes to the host when the buffer is full or the latency timer expires.
// - Host line settings such as baud rate and handshaking have no effect on the device.
// - All serial protocol handling is internal; the host sees only raw payload bytes.
// - Toward the host the device is a plain byte bridge like a serial-port converter.
// - On every enumeration taken while clkEn is high the stored serial-port option bit is read and reported.
// - The serial-port option reads as disabled until it is programmed otherwise.
// - A read address is not acknowledged while the transmit buffer is empty and no 0x0c count read is pending.
// - A write address or data byte is not acknowledged when it would not fit.
// - One pin shows pending transmit bytes and another shows free receive space.
// - After general-call command 0x0c the next read returns the count, saturated at 0xff.
`default_nettype none
`include "bridge_defs.svh"

module sync_fifo #(
    parameter int WIDTH = `BYTE_WIDTH,
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int LW = $clog2(DEPTH + 1)
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic flush,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [LW-1:0] level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    wire logic push = inValid && inReady;
    wire logic pop = outValid && outReady;
    wire logic [LW-1:0] next_level = LW'(level + LW'(push) - LW'(pop));
    wire logic [AW-1:0] wrInc = (wrPtr == LAST_SLOT) ? '0 : AW'(wrPtr + 1'b1);
    wire logic [AW-1:0] rdInc = (rdPtr == LAST_SLOT) ? '0 : AW'(rdPtr + 1'b1);

    // The head entry is read straight from the array; order is strict.
    assign outData = mem[rdPtr];

    always_ff @(posedge mclk) begin
        if (clkEn && push) begin
            mem[wrPtr] <= inData;
        end
    end

    // Full and empty are kept as flags so that both readies come from flops.
    always_ff @(posedge mclk) begin
        if (!rst_b || (clkEn && flush)) begin
            wrPtr <= '0;
            rdPtr <= '0;
            level <= '0;
            inReady <= 1'b1;
            outValid <= 1'b0;
        end else if (clkEn) begin
            wrPtr <= push ? wrInc : wrPtr;
            rdPtr <= pop ? rdInc : rdPtr;
            level <= next_level;
            inReady <= next_level != FULL_LEVEL;
            outValid <= next_level != '0;
        end
    end
endmodule

module usb_to_i2c_slave_data_bridge import bridge_pkg::*; #(
    parameter int DEPTH = `FIFO_DEPTH,
    parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEFAULT,
    parameter int LATENCY_CYCLES = `LATENCY_TIME_US * `MCLK_MHZ
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [7:0] hostTxData,
    input wire logic hostTxValid,
    output logic hostTxReady,
    output logic [7:0] hostRxData,
    output logic hostRxValid,
    input wire logic hostRxReady,
    input wire logic usbEnumerate,
    input wire logic cfgVcpOption,
    output logic virtualSerialPortLayer,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    output logic txDataPendingN,
    output logic rxSpaceFreeN
);
    localparam int LW = $clog2(DEPTH + 1);
    localparam int TW = $clog2(LATENCY_CYCLES + 1);
    localparam logic [TW-1:0] TIMER_LAST = TW'(LATENCY_CYCLES - 1);

    line_s syncA;
    line_s syncB;
    line_s prevLine;
    line_state_e state;
    logic [3:0] bitCnt;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic isRead;
    logic isGc;
    logic countPending;
    logic masterAck;
    logic forwarding;
    logic [TW-1:0] latencyTimer;
    logic txOutValid;
    logic [7:0] txHead;
    logic [LW-1:0] txLevel;
    logic rxInReady;
    logic rxOutValid;
    logic [7:0] rxHead;
    logic [LW-1:0] rxLevel;

    wire logic sclRise = !prevLine.scl && syncB.scl;
    wire logic sclFall = prevLine.scl && !syncB.scl;
    wire logic startSeen = prevLine.scl && syncB.scl && prevLine.sda && !syncB.sda;
    wire logic stopSeen = prevLine.scl && syncB.scl && !prevLine.sda && syncB.sda;
    wire logic byteDone = sclFall && bitCnt == `BYTE_BITS;
    wire logic addrHit = shiftIn[7:1] == SLAVE_ADDR;
    wire logic gcHit = shiftIn == `GC_ADDRESS;
    wire logic ackRead = addrHit && shiftIn[0] && (countPending || txOutValid);
    wire logic ackWrite = addrHit && !shiftIn[0] && rxInReady;
    wire logic addrAck = ackRead || ackWrite || gcHit;
    wire logic loadByte = sclFall && ((state == LINE_ADDR_ACK && isRead) ||
                                      (state == LINE_RD_ACK && masterAck));
    wire logic [15:0] txLevelWide = 16'(txLevel);
    wire logic [7:0] countByte = (txLevelWide >= `COUNT_SATURATE) ?
                                 8'(`COUNT_SATURATE) : txLevelWide[7:0];
    wire logic [7:0] nextByte = countPending ? countByte :
                                (txOutValid ? txHead : `EMPTY_READ_BYTE);
    wire logic txPop = loadByte && !countPending && txOutValid;
    wire logic wrByte = byteDone && state == LINE_WR_DATA;
    wire logic rxPush = wrByte && !isGc && rxInReady;
    wire logic wrAck = isGc || rxInReady;
    wire logic flushAll = wrByte && isGc &&
                          (shiftIn == `GC_CMD_RESET || shiftIn == `GC_CMD_FLUSH);
    wire logic rxPop = forwarding && rxOutValid && (!hostRxValid || hostRxReady);

    // Transmit buffer: raw host payload in, drained by slave reads.
    sync_fifo #(.WIDTH(8), .DEPTH(DEPTH), .LW(LW)) txFifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .flush(flushAll),
        .inValid(hostTxValid),
        .inReady(hostTxReady),
        .inData(hostTxData),
        .outValid(txOutValid),
        .outReady(txPop),
        .outData(txHead),
        .level(txLevel)
    );

    // Receive buffer: bytes written by the master, drained toward the host.
    sync_fifo #(.WIDTH(8), .DEPTH(DEPTH), .LW(LW)) rxFifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .flush(flushAll),
        .inValid(rxPush),
        .inReady(rxInReady),
        .inData(shiftIn),
        .outValid(rxOutValid),
        .outReady(rxPop),
        .outData(rxHead),
        .level(rxLevel)
    );

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            syncA <= '1;
            syncB <= '1;
            prevLine <= '1;
        end else if (clkEn) begin
            syncA <= '{scl: sclIn, sda: sdaIn};
            syncB <= syncA;
            prevLine <= syncB;
        end
    end

    // The host stream carries payload only; no line settings reach this logic.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            hostRxValid <= 1'b0;
            hostRxData <= '0;
        end else if (clkEn) begin
            if (rxPop) begin
                hostRxValid <= 1'b1;
                hostRxData <= rxHead;
            end else if (hostRxReady) begin
                hostRxValid <= 1'b0;
            end
        end
    end

    // Forwarding opens on a full buffer or timer expiry, and runs until a pop is taken at level one.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            forwarding <= 1'b0;
            latencyTimer <= '0;
        end else if (clkEn) begin
            if (forwarding) begin
                forwarding <= rxOutValid && !(rxPop && rxLevel == LW'(1));
                latencyTimer <= '0;
            end else if (!rxOutValid) begin
                latencyTimer <= '0;
            end else if (!rxInReady || latencyTimer == TIMER_LAST) begin
                forwarding <= 1'b1;
                latencyTimer <= '0;
            end else begin
                latencyTimer <= TW'(latencyTimer + 1'b1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            virtualSerialPortLayer <= 1'b0;
            txDataPendingN <= 1'b1;
            rxSpaceFreeN <= 1'b1;
            sdaOut <= 1'b0;
        end else if (clkEn) begin
            if (usbEnumerate) begin
                virtualSerialPortLayer <= cfgVcpOption;
            end
            txDataPendingN <= !txOutValid;
            rxSpaceFreeN <= !rxInReady;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state <= LINE_IDLE;
            bitCnt <= '0;
            shiftIn <= '0;
            shiftOut <= '0;
            isRead <= 1'b0;
            isGc <= 1'b0;
            countPending <= 1'b0;
            masterAck <= 1'b0;
            sdaOeN <= 1'b1;
        end else if (clkEn) begin
            if (startSeen) begin
                state <= LINE_ADDR;
                bitCnt <= '0;
                sdaOeN <= 1'b1;
            end else if (stopSeen) begin
                state <= LINE_IDLE;
                sdaOeN <= 1'b1;
            end else if (sclRise) begin
                shiftIn <= {shiftIn[6:0], syncB.sda};
                bitCnt <= 4'(bitCnt + 1'b1);
                if (state == LINE_RD_ACK) begin
                    masterAck <= !syncB.sda;
                end
            end else if (sclFall) begin
                case (state)
                    LINE_ADDR: begin
                        if (byteDone && addrAck) begin
                            sdaOeN <= 1'b0;
                            state <= LINE_ADDR_ACK;
                            isRead <= shiftIn[0] && !gcHit;
                            isGc <= gcHit;
                        end else if (byteDone) begin
                            state <= LINE_IDLE;
                        end
                    end
                    LINE_ADDR_ACK, LINE_RD_ACK: begin
                        bitCnt <= '0;
                        if (loadByte) begin
                            shiftOut <= {nextByte[6:0], 1'b0};
                            sdaOeN <= nextByte[7];
                            countPending <= 1'b0;
                            state <= LINE_RD_DATA;
                        end else if (state == LINE_ADDR_ACK) begin
                            sdaOeN <= 1'b1;
                            state <= LINE_WR_DATA;
                        end else begin
                            state <= LINE_IDLE;
                        end
                    end
                    LINE_WR_DATA: begin
                        if (byteDone) begin
                            sdaOeN <= !wrAck;
                            state <= LINE_WR_ACK;
                            if (isGc && shiftIn == `GC_CMD_COUNT) begin
                                countPending <= 1'b1;
                            end
                        end
                    end
                    LINE_WR_ACK: begin
                        sdaOeN <= 1'b1;
                        bitCnt <= '0;
                        state <= LINE_WR_DATA;
                    end
                    LINE_RD_DATA: begin
                        if (byteDone) begin
                            sdaOeN <= 1'b1;
                            state <= LINE_RD_ACK;
                        end else begin
                            sdaOeN <= shiftOut[7];
                            shiftOut <= {shiftOut[6:0], 1'b0};
                        end
                    end
                    default: begin
                        state <= LINE_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

`default_nettype wire
